// [hw/core_timing_pkg.sv]
// Shared constants and carrier types for the instruction timing core
package core_timing_pkg;
    // Longest instruction; only the divide reaches it
    localparam logic [3:0] MAX_CYCLES = 4'h8;
    localparam int TOTAL_INSTRUCTIONS = 109;
    // Instructions per timing class: 1,2,2/3,3,3/4,4,4/5,5,8
    localparam int CLASS_1 = 26;
    localparam int CLASS_2 = 50;
    localparam int CLASS_2_3 = 5;
    localparam int CLASS_3 = 14;
    localparam int CLASS_3_4 = 7;
    localparam int CLASS_4 = 3;
    localparam int CLASS_4_5 = 1;
    localparam int CLASS_5 = 2;
    localparam int CLASS_8 = 1;
    // Clock rates, used only to state peak throughput
    localparam int CLK_MHZ = 250;
    localparam int REF_CLK_MHZ = 25;
    localparam int REF_PEAK_MIPS = 25;

    // Arithmetic opcode groups (upper nibble) and lowest arithmetic lower nibble
    localparam logic [3:0] GRP_ADD = 4'h2;
    localparam logic [3:0] GRP_ADDC = 4'h3;
    localparam logic [3:0] GRP_SUBB = 4'h9;
    localparam logic [3:0] LOW_ARITH_MIN = 4'h4;

    // Flag positions within program_status_flags
    localparam int FLAG_CY = 7;
    localparam int FLAG_AC = 6;
    localparam int FLAG_OV = 2;
    localparam int FLAG_P = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    typedef struct packed {
        logic [1:0] bytes;
        logic [3:0] cycles;
        logic cond;
    } timing_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] acc;
        logic [7:0] operand;
        logic [7:0] flags;
        logic taken;
    } issue_t;

    typedef struct packed {
        logic [1:0] bytes;
        logic [3:0] cycles;
        logic [7:0] opcode;
        logic [7:0] result;
        logic [7:0] flags;
    } retire_t;
endpackage

// [hw/opcode_timing.sv]
// Opcode to length and cycle-count decoder
`timescale 1ns/10ps
module opcode_timing (
    input wire logic [7:0] opcode,
    output core_timing_pkg::timing_t timing
);
    function automatic core_timing_pkg::timing_t mk(
        input logic [1:0] b,
        input logic [3:0] c,
        input logic cd
    );
        core_timing_pkg::timing_t t;
        t.bytes = b;
        t.cycles = c;
        t.cond = cd;
        return t;
    endfunction

    logic [3:0] hi;
    logic [3:0] lo;

    always_comb begin
        hi = opcode[7:4];
        lo = opcode[3:0];
        timing = mk(2'h1, 4'h1, 1'b0);
        if (lo[3]) begin
            case (hi)
                4'h7, 4'hA: timing = mk(2'h2, 4'h2, 1'b0);
                4'h8: timing = mk(2'h2, 4'h2, 1'b0);
                4'hB: timing = mk(2'h3, 4'h3, 1'b1);
                4'hD: timing = mk(2'h2, 4'h2, 1'b1);
                default: timing = mk(2'h1, 4'h1, 1'b0);
            endcase
        end else if (lo[3:1] == 3'h3) begin
            case (hi)
                4'h7: timing = mk(2'h2, 4'h2, 1'b0);
                4'h8, 4'hA: timing = mk(2'h2, 4'h2, 1'b0);
                4'hB: timing = mk(2'h3, 4'h4, 1'b1);
                default: timing = mk(2'h1, 4'h2, 1'b0);
            endcase
        end else if (lo == 4'h5) begin
            case (hi)
                4'h7, 4'h8: timing = mk(2'h3, 4'h3, 1'b0);
                4'hB, 4'hD: timing = mk(2'h3, 4'h3, 1'b1);
                4'hA: timing = mk(2'h1, 4'h1, 1'b0);
                default: timing = mk(2'h2, 4'h2, 1'b0);
            endcase
        end else if (lo == 4'h4) begin
            case (hi)
                4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF:
                    timing = mk(2'h1, 4'h1, 1'b0);
                4'h8: timing = mk(2'h1, 4'h8, 1'b0);
                4'hA: timing = mk(2'h1, 4'h4, 1'b0);
                4'hB: timing = mk(2'h3, 4'h3, 1'b1);
                default: timing = mk(2'h2, 4'h2, 1'b0);
            endcase
        end else if (lo == 4'h1) begin
            timing = mk(2'h2, 4'h3, 1'b0);
        end else if (lo == 4'h0) begin
            case (hi)
                4'h0: timing = mk(2'h1, 4'h1, 1'b0);
                4'h1, 4'h2, 4'h3: timing = mk(2'h3, 4'h3, 1'b1);
                4'h4, 4'h5, 4'h6, 4'h7: timing = mk(2'h2, 4'h2, 1'b1);
                4'h8: timing = mk(2'h2, 4'h3, 1'b0);
                4'h9: timing = mk(2'h3, 4'h3, 1'b0);
                4'hE, 4'hF: timing = mk(2'h1, 4'h3, 1'b0);
                default: timing = mk(2'h2, 4'h2, 1'b0);
            endcase
        end else if (lo == 4'h2) begin
            case (hi)
                4'h0: timing = mk(2'h3, 4'h4, 1'b0);
                4'h1: timing = mk(2'h3, 4'h4, 1'b0);
                4'h2, 4'h3: timing = mk(2'h1, 4'h5, 1'b0);
                4'h4, 4'h5, 4'h6: timing = mk(2'h2, 4'h2, 1'b0);
                4'hE, 4'hF: timing = mk(2'h1, 4'h3, 1'b0);
                default: timing = mk(2'h2, 4'h2, 1'b0);
            endcase
        end else begin
            case (hi)
                4'h4, 4'h5, 4'h6: timing = mk(2'h3, 4'h3, 1'b0);
                4'h7, 4'h8, 4'h9, 4'hE, 4'hF:
                    timing = mk(2'h1, 4'h3, 1'b0);
                default: timing = mk(2'h1, 4'h1, 1'b0);
            endcase
        end
    end
endmodule

// [hw/instr_sequencer.sv]
// Instruction issue, cycle timing and arithmetic flag sequencer
//
// Functional notes
// - Durations counted in plain clock cycles.
// - Most instructions take one cycle per byte.
// - Untaken conditional branch is one cycle shorter.
// - Eight cycles at most; only divide.
// - Classic encodings kept; flags updated only by add/addc/subb.
// - Add/addc/subb: register 1, direct/immediate 2.
// - Indirect RAM arithmetic/logic takes 2 cycles.
// - Data pointer increment takes one cycle.
// - Inc/dec: A or register 1, else 2.
// - AND/OR immediate into direct: 3 cycles.
// - AND/OR/XOR A into direct: 2 cycles.
// - 109 instructions implemented in total.
// - Per-class instruction counts as tabulated.
// - Single-cycle instructions retire every clock.
// - Bit-test jumps: 3 untaken, 4 taken.
// - Long call 4 cycles, return 5.
`timescale 1ns/10ps
module instr_sequencer (
    input wire logic clk,
    input wire logic srst,
    input wire logic issue_valid,
    input core_timing_pkg::issue_t issue,
    output logic issue_ready,
    output logic retire_valid,
    output core_timing_pkg::retire_t retire,
    output logic [7:0] program_status_flags
);
    typedef struct packed {
        logic ready;
        logic [3:0] remain;
        logic pending;
        core_timing_pkg::retire_t info;
        logic retire_valid;
        core_timing_pkg::retire_t out;
        logic [7:0] flags;
    } state_t;

    // Result, carry, auxiliary carry and overflow of add or subtract
    function automatic logic [10:0] arith(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic cin,
        input logic sub
    );
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] bb;
        logic ov;
        bb = sub ? ~b : b;
        full = {1'b0, a} + {1'b0, bb} + {8'h00, sub ^ cin};
        low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub ^ cin};
        ov = (a[7] == bb[7]) && (full[7] != a[7]);
        // Subtraction reports borrow, the inverse of the carry out
        return {full[8] ^ sub, low[4] ^ sub, ov, full[7:0]};
    endfunction

    state_t state;
    state_t next_state;
    core_timing_pkg::timing_t timing;
    logic accept;
    logic is_arith;
    logic is_sub;
    logic use_carry;
    logic [3:0] dur;
    logic [10:0] alu;
    logic [7:0] new_flags;

    opcode_timing decoder (
        .opcode(issue.opcode),
        .timing(timing)
    );

    always_comb begin
        next_state = state;
        accept = issue_valid && state.ready;
        // Taken branches pay one extra cycle
        dur = timing.cycles + {3'h0, timing.cond & issue.taken};
        is_arith = (issue.opcode[7:4] == core_timing_pkg::GRP_ADD
            || issue.opcode[7:4] == core_timing_pkg::GRP_ADDC
            || issue.opcode[7:4] == core_timing_pkg::GRP_SUBB)
            && issue.opcode[3:0] >= core_timing_pkg::LOW_ARITH_MIN;
        is_sub = issue.opcode[7:4] == core_timing_pkg::GRP_SUBB;
        use_carry = issue.opcode[7:4] != core_timing_pkg::GRP_ADD;
        alu = arith(issue.acc, issue.operand,
            use_carry & issue.flags[core_timing_pkg::FLAG_CY], is_sub);
        new_flags = issue.flags;
        if (is_arith) begin
            new_flags[core_timing_pkg::FLAG_CY] = alu[10];
            new_flags[core_timing_pkg::FLAG_AC] = alu[9];
            new_flags[core_timing_pkg::FLAG_OV] = alu[8];
            new_flags[core_timing_pkg::FLAG_P] = ^alu[7:0];
        end
        next_state.retire_valid = 1'b0;
        if (state.pending && state.remain == 4'h1) begin
            // Last busy cycle; release issue for the next edge
            next_state.pending = 1'b0;
            next_state.remain = 4'h0;
            next_state.ready = 1'b1;
            next_state.retire_valid = 1'b1;
            next_state.out = state.info;
        end else if (state.pending) begin
            next_state.remain = state.remain - 4'h1;
        end
        if (accept) begin
            next_state.info.bytes = timing.bytes;
            next_state.info.cycles = dur;
            next_state.info.opcode = issue.opcode;
            next_state.info.result = is_arith ? alu[7:0] : issue.acc;
            next_state.info.flags = new_flags;
            next_state.flags = new_flags;
            if (dur <= 4'h1) begin
                // Back to back issue gives one retire per clock
                next_state.retire_valid = 1'b1;
                next_state.out = next_state.info;
                next_state.ready = 1'b1;
            end else begin
                next_state.pending = 1'b1;
                next_state.remain = dur - 4'h1;
                next_state.ready = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= '0;
            state.ready <= 1'b1;
            state.flags <= core_timing_pkg::FLAGS_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign issue_ready = state.ready;
    assign retire_valid = state.retire_valid;
    assign retire = state.out;
    assign program_status_flags = state.flags;
endmodule

// [testbench/instr_seq_monitor.sv]
// Timing and flag assertions on the instruction sequencer ports
`timescale 1ns/10ps
module instr_seq_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic issue_valid,
    input core_timing_pkg::issue_t issue,
    input wire logic issue_ready,
    input wire logic retire_valid,
    input core_timing_pkg::retire_t retire,
    input wire logic [7:0] program_status_flags
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic acc_now;
    logic [3:0] since;
    assign acc_now = issue_valid && issue_ready;
    // Saturates so a long idle never wraps into a false match
    always_ff @(posedge clk) begin
        if (srst) since <= 4'h0;
        else if (acc_now) since <= 4'h1;
        else if (since != 4'hF) since <= since + 4'h1;
    end
    a_reset_state: assert property (disable iff (1'b0)
        srst |=> issue_ready && !retire_valid && program_status_flags == 8'h00)
        else $error("state after reset wrong");
    a_retire_delay: assert property (
        retire_valid |-> since == retire.cycles)
        else $error("retire not at reported cycle count");
    a_max_cycles: assert property (
        retire_valid |-> retire.cycles <= core_timing_pkg::MAX_CYCLES
            && retire.cycles != 4'h0)
        else $error("cycle count out of range");
    a_div_eight: assert property (
        acc_now && issue.opcode == 8'h84 |=> !issue_ready [*7]
            ##1 (retire_valid && retire.cycles == 4'h8))
        else $error("divide not eight cycles");
    a_jb_taken: assert property (
        acc_now && issue.opcode == 8'h20 && issue.taken
            |=> !issue_ready [*3] ##1 retire_valid)
        else $error("taken bit jump not four cycles");
    a_jb_untaken: assert property (
        acc_now && issue.opcode == 8'h20 && !issue.taken
            |=> !issue_ready [*2] ##1 retire_valid)
        else $error("untaken bit jump not three cycles");
    a_single_back: assert property (
        acc_now && issue.opcode inside {8'h28, 8'hA3, 8'h04}
            |=> retire_valid && issue_ready && retire.cycles == 4'h1)
        else $error("single cycle op stalled");
    a_flags_follow: assert property (
        retire_valid |-> program_status_flags == retire.flags)
        else $error("flag port differs from retired flags");
    a_indirect_two: assert property (
        retire_valid && retire.opcode[3:1] == 3'h3 && retire.opcode[7:4]
            inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}
            |-> retire.cycles == 4'h2 && retire.bytes == 2'h1)
        else $error("indirect operand op not two cycles");
endmodule
bind instr_sequencer instr_seq_monitor i_mon (.clk(clk), .srst(srst),
    .issue_valid(issue_valid), .issue(issue), .issue_ready(issue_ready),
    .retire_valid(retire_valid), .retire(retire),
    .program_status_flags(program_status_flags));

// [testbench/prog_mem_model.sv]
// Program and data memory model feeding a fixed instruction list
`timescale 1ns/10ps
module prog_mem_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic go,
    input wire logic issue_ready,
    output logic issue_valid,
    output core_timing_pkg::issue_t issue
);
    localparam logic [7:0] OPS [15] = '{8'h28, 8'h29, 8'h98, 8'h34,
        8'h84, 8'h20, 8'h20, 8'hA3, 8'h53, 8'h62, 8'h26, 8'h05, 8'h04,
        8'h12, 8'h22};
    logic [3:0] pc;
    always_comb begin
        issue_valid = go && pc < 4'hF;
        issue = '0;
        issue.opcode = OPS[pc % 15];
        case (pc)
            4'h0: {issue.acc, issue.operand} = 16'h7F01;
            4'h1: {issue.acc, issue.operand} = 16'hFF01;
            4'h2: {issue.operand, issue.flags} = 16'h0180;
            4'h3: {issue.acc, issue.operand, issue.flags} = 24'h102080;
            4'h5: issue.taken = 1'b1;
            default: ;
        endcase
        // Idle bus must not mimic the last instruction
        if (!issue_valid) issue = ~issue;
    end
    always_ff @(posedge clk) begin
        if (srst) pc <= 4'h0;
        else if (issue_valid && issue_ready) pc <= pc + 4'h1;
    end
endmodule

// [testbench/instr_sequencer_bench.sv]
// Self-checking bench for the instruction timing sequencer
`timescale 1ns/10ps
module instr_sequencer_bench;
    logic clk;
    logic srst = 1'b1;
    logic go = 1'b0;
    logic issue_valid, issue_ready, retire_valid;
    core_timing_pkg::issue_t issue;
    core_timing_pkg::retire_t retire;
    logic [7:0] program_status_flags;
    int n_fail = 0;
    int n_tests = 0;
    localparam int EXP_C [15] = '{1,1,1,2,8,4,3,1,3,2,2,2,1,4,5};
    localparam int EXP_B [15] = '{1,1,1,2,1,3,3,1,3,2,1,2,1,3,1};
    localparam logic [7:0] EXP_R [4] = '{8'h80, 8'h00, 8'hFE, 8'h31};
    localparam logic [7:0] EXP_F [4] = '{8'h45, 8'hC0, 8'hC1, 8'h01};
    localparam logic [7:0] EXP_O [15] = '{8'h28, 8'h29, 8'h98, 8'h34,
        8'h84, 8'h20, 8'h20, 8'hA3, 8'h53, 8'h62, 8'h26, 8'h05, 8'h04,
        8'h12, 8'h22};
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    instr_sequencer i_dut (.clk(clk), .srst(srst),
        .issue_valid(issue_valid), .issue(issue),
        .issue_ready(issue_ready), .retire_valid(retire_valid),
        .retire(retire), .program_status_flags(program_status_flags));
    prog_mem_model i_mem (.clk(clk), .srst(srst), .go(go),
        .issue_ready(issue_ready), .issue_valid(issue_valid),
        .issue(issue));
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic reset_check;
        go <= 1'b0;
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        #1;
        check("handshake", {6'h0, retire_valid, issue_ready}, 8'h01);
        check("flags_rst", program_status_flags, 8'h00);
        check("retire_rst", retire.opcode, 8'h00);
    endtask
    // Reset lands inside the divide to show no retire leaks out
    task automatic abort_run;
        @(posedge clk);
        go <= 1'b1;
        repeat (7) @(posedge clk);
        #1;
        // Divide still busy, last retire was the immediate addc
        check("busy", {6'h0, retire_valid, issue_ready}, 8'h00);
        check("last_retire", retire.opcode, 8'h34);
        @(posedge clk);
    endtask
    task automatic run_program;
        int i = 0;
        int gap = 0;
        @(posedge clk);
        go <= 1'b1;
        while (i < 15 && gap < 12) begin
            @(posedge clk);
            #1;
            gap++;
            if (retire_valid === 1'b1) begin
                check("cycles", 8'(retire.cycles), 8'(EXP_C[i]));
                check("bytes", 8'(retire.bytes), 8'(EXP_B[i]));
                check("opcode", retire.opcode, EXP_O[i]);
                if (i > 0) check("spacing", 8'(gap), 8'(EXP_C[i]));
                check("result", retire.result, i < 4 ? EXP_R[i] : 8'h00);
                check("flags", program_status_flags,
                    i < 4 ? EXP_F[i] : 8'h00);
                i++;
                gap = 0;
            end
        end
        check("retired", 8'(i), 8'h0F);
    endtask
    initial begin
        reset_check();
        abort_run();
        reset_check();
        run_program();
        conclude();
    end
    // Whole run needs well under a hundred cycles
    initial begin
        repeat (2000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule
